/* File: atpg_top.sv */
// converter test-pattern generator placed ahead of the output formatting stage
// Function
// (RULE1) 4-bit control code selects pattern; zero off
// (RULE2) nonzero code replaces converter samples with pattern; unused codes 9-14 pass converter samples here
// (RULE3) pattern passes formatting; some types bypass it
// (RULE4) either reset bit reseeds pseudo-random generators
// (RULE5) analog ignored; advance only on sample clock
// (RULE6) codes 1-3 give midscale, +full, -full
// (RULE7) code 4 alternates 0x1555 and 0x2aaa
// (RULE8) code 5 long sequence x^23+x^18+1
// (RULE9) code 6 short sequence x^9+x^5+1
// (RULE10) code 7 alternates all zeros, all ones
// (RULE11) code 8 repeat: user patterns one-four cycling
// (RULE12) code 8 single: four user patterns, then zeros
// (RULE13) code 15 ramp, plus one, wraps 2^14
// (RULE14) repeat or single chosen by control bit
// (RULE15) generators step once per sample; ramp restarts
`timescale 1ns/10ps
`default_nettype none
module atpg_top #(
   parameter int unsigned ADDR_W = atpg_pkg::ADDR_W
) (
   input  wire logic                 mclk,          // sample-rate clock, 200 MHz
   input  wire logic                 rst_n,         // synchronous reset, active low
   input  wire logic [ADDR_W-1:0]    reg_addr,      // register address
   input  wire logic [7:0]           reg_wdata,     // register write data
   input  wire logic                 reg_we,        // register write strobe
   input  wire logic                 fmt_offset_bin,// formatter: 1 = offset binary
   input  wire atpg_pkg::atpg_sample_t adc_in,      // converter sample, valid = encode tick
   output logic [7:0]                reg_rdata,     // read data, one cycle after address
   output atpg_pkg::atpg_sample_t    data_out,      // formatted sample to back end
   output logic                      test_active    // a nonzero pattern code is selected
);
   logic [7:0]  control;
   logic [7:0]  user_byte [atpg_pkg::USER_BYTES];
   logic [3:0]  mode;
   logic        ctl_write;
   logic        mode_enter;
   logic        tick;
   logic        phase;
   logic [1:0]  user_idx;
   logic        user_done;
   logic [13:0] ramp;
   logic [atpg_pkg::LONG_W-1:0]  long_st;
   logic [atpg_pkg::SHORT_W-1:0] short_st;
   logic [atpg_pkg::LONG_W-1:0]  next_long_st;
   logic [atpg_pkg::SHORT_W-1:0] next_short_st;
   logic [13:0] long_word;
   logic [13:0] short_word;
   logic [13:0] user_word;
   logic [13:0] pat_word;
   logic        pat_fmt;
   logic [13:0] next_data;

   assign mode       = control[atpg_pkg::CTL_MODE_LSB +: atpg_pkg::CTL_MODE_W]; // RULE1
   assign tick       = adc_in.valid; // RULE5
   assign ctl_write  = reg_we && (reg_addr == atpg_pkg::OFS_CONTROL);

   // a write that changes the code restarts ramp, phase and user index on that edge,
   // so a tick on the very next edge already sees the fresh per-mode state
   assign mode_enter = ctl_write
                    && (reg_wdata[atpg_pkg::CTL_MODE_LSB +: atpg_pkg::CTL_MODE_W] != mode); // RULE15

   // control register write
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         control <= atpg_pkg::CONTROL_RESET; // RULE1 RULE14
      end else if (ctl_write) begin
         control <= reg_wdata;
      end
   end

   // user pattern byte registers
   for (genvar i = 0; i < atpg_pkg::USER_BYTES; i++) begin : g_user
      always_ff @(posedge mclk) begin
         if (!rst_n) begin
            user_byte[i] <= atpg_pkg::USER_RESET;
         end else if (reg_we && reg_addr == atpg_pkg::OFS_USER_BASE + 12'(i)) begin
            user_byte[i] <= reg_wdata;
         end
      end
   end

   // registered read-back, unmapped addresses read zero
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_addr == atpg_pkg::OFS_CONTROL) begin
         reg_rdata <= control;
      end else if (reg_addr >= atpg_pkg::OFS_USER_BASE && reg_addr <= atpg_pkg::OFS_USER_LAST) begin
         reg_rdata <= user_byte[3'(reg_addr - atpg_pkg::OFS_USER_BASE)];
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // advance a generator fourteen bit-steps, output bits collected msb first;
   // the register holds the coming output bits with the oldest in bit 0: each step
   // emits bit 0, shifts right and enters the tap sum of bit 0 and bit W-TAP at the top
   function automatic logic [36:0] step_long(input logic [22:0] s);
      logic [22:0] st;
      logic [13:0] w;
      st = s;
      w  = 14'h0000;
      for (int k = 0; k < 14; k++) begin
         w  = {w[12:0], st[0]};
         st = {st[0] ^ st[atpg_pkg::LONG_W-atpg_pkg::LONG_TAP], st[22:1]};
      end
      return {st, w};
   endfunction : step_long

   // short generator, same walk over nine bits
   function automatic logic [22:0] step_short(input logic [8:0] s);
      logic [8:0]  st;
      logic [13:0] w;
      st = s;
      w  = 14'h0000;
      for (int k = 0; k < 14; k++) begin
         w  = {w[12:0], st[0]};
         st = {st[0] ^ st[atpg_pkg::SHORT_W-atpg_pkg::SHORT_TAP], st[8:1]};
      end
      return {st, w};
   endfunction : step_short

   assign {next_long_st, long_word}   = step_long(long_st);   // RULE8
   assign {next_short_st, short_word} = step_short(short_st); // RULE9

   // long pseudo-random generator; either reset bit holds it at its seed
   // for as long as the bit stays set, so software must clear it again
   always_ff @(posedge mclk) begin
      if (!rst_n || control[atpg_pkg::CTL_LONG_RST] || control[atpg_pkg::CTL_SHORT_RST]) begin
         long_st <= atpg_pkg::LONG_SEED; // RULE4
      end else if (tick && mode == atpg_pkg::MODE_LONG_PR) begin
         long_st <= next_long_st; // RULE15
      end
   end

   // short pseudo-random generator; shares both reset bits with the long one
   // so one write reseeds the pair and their reference words line up again
   always_ff @(posedge mclk) begin
      if (!rst_n || control[atpg_pkg::CTL_LONG_RST] || control[atpg_pkg::CTL_SHORT_RST]) begin
         short_st <= atpg_pkg::SHORT_SEED; // RULE4
      end else if (tick && mode == atpg_pkg::MODE_SHORT_PR) begin
         short_st <= next_short_st; // RULE15
      end
   end

   // ramp counter, restarts from zero when its mode is entered
   always_ff @(posedge mclk) begin
      if (!rst_n || mode_enter) begin
         ramp <= 14'h0000; // RULE15
      end else if (tick && mode == atpg_pkg::MODE_RAMP) begin
         ramp <= ramp + 14'h0001; // RULE13
      end
   end

   // alternating phase for checkerboard and word toggle
   always_ff @(posedge mclk) begin
      if (!rst_n || mode_enter) begin
         phase <= 1'b0;
      end else if (tick) begin
         phase <= ~phase; // RULE7 RULE10
      end
   end

   // user pattern sequencer
   always_ff @(posedge mclk) begin
      if (!rst_n || mode_enter) begin
         user_idx  <= 2'd0;
         user_done <= 1'b0;
      end else if (tick && mode == atpg_pkg::MODE_USER) begin
         user_idx <= user_idx + 2'd1; // RULE11
         if (user_idx == 2'd3 && control[atpg_pkg::CTL_SINGLE]) begin
            user_done <= 1'b1; // RULE12 RULE14
         end
      end
   end

   // user pattern k is bytes {2k+1, 2k}; upper 14 bits of 16 are sent
   assign user_word = user_done ? atpg_pkg::WORD_ZEROS
                    : {user_byte[{user_idx, 1'b1}], user_byte[{user_idx, 1'b0}][7:2]}; // RULE11 RULE12

   // pattern select; pat_fmt marks words that go through the formatter
   always_comb begin
      pat_word = atpg_pkg::WORD_ZEROS;
      pat_fmt  = 1'b0;
      unique case (mode)
         atpg_pkg::MODE_MIDSCALE: begin pat_word = atpg_pkg::WORD_MIDSCALE; pat_fmt = 1'b1; end // RULE6
         atpg_pkg::MODE_POS_FS:   begin pat_word = atpg_pkg::WORD_POS_FS;   pat_fmt = 1'b1; end // RULE6
         atpg_pkg::MODE_NEG_FS:   begin pat_word = atpg_pkg::WORD_NEG_FS;   pat_fmt = 1'b1; end // RULE6
         atpg_pkg::MODE_CHECKER:  pat_word = phase ? atpg_pkg::WORD_CHECK_B : atpg_pkg::WORD_CHECK_A; // RULE7
         atpg_pkg::MODE_LONG_PR:  pat_word = long_word;  // RULE8
         atpg_pkg::MODE_SHORT_PR: pat_word = short_word; // RULE9
         atpg_pkg::MODE_TOGGLE:   pat_word = phase ? atpg_pkg::WORD_ONES : atpg_pkg::WORD_ZEROS; // RULE10
         atpg_pkg::MODE_USER:     pat_word = user_word;
         atpg_pkg::MODE_RAMP:     begin pat_word = ramp; pat_fmt = 1'b1; end // RULE13
         default: begin
            pat_word = adc_in.data; // off or unused code: converter path
            pat_fmt  = 1'b1;
         end
      endcase
   end

   // formatter: offset binary flips the sign bit of formatted words
   assign next_data = {pat_word[13] ^ (pat_fmt & fmt_offset_bin), pat_word[12:0]}; // RULE3

   // output stage, new word on each encode tick;
   // data holds between ticks so the back end always sees the last word
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         data_out    <= '0;
         test_active <= 1'b0;
      end else begin
         data_out.valid <= tick; // RULE5
         if (tick) begin
            data_out.data <= next_data; // RULE2
         end
         test_active <= (mode != atpg_pkg::MODE_OFF); // RULE2
      end
   end
endmodule : atpg_top
`default_nettype wire

/* File: atpg_pkg.sv */
// package of constants and types for the converter test-pattern generator
package atpg_pkg;
   localparam int unsigned SAMPLE_W   = 14;
   localparam int unsigned ADDR_W     = 12;
   // register offsets
   localparam logic [11:0] OFS_CONTROL   = 12'h550;
   localparam logic [11:0] OFS_USER_BASE = 12'h551;
   localparam logic [11:0] OFS_USER_LAST = 12'h558;
   localparam int unsigned USER_BYTES    = 8;
   // control register fields and reset value
   localparam int unsigned CTL_MODE_LSB   = 0;
   localparam int unsigned CTL_MODE_W     = 4;
   localparam int unsigned CTL_LONG_RST   = 4;
   localparam int unsigned CTL_SHORT_RST  = 5;
   localparam int unsigned CTL_SINGLE     = 6;
   localparam logic [7:0]  CONTROL_RESET  = 8'h00;
   localparam logic [7:0]  USER_RESET     = 8'h00;
   // pattern codes
   localparam logic [3:0] MODE_OFF      = 4'h0;
   localparam logic [3:0] MODE_MIDSCALE = 4'h1;
   localparam logic [3:0] MODE_POS_FS   = 4'h2;
   localparam logic [3:0] MODE_NEG_FS   = 4'h3;
   localparam logic [3:0] MODE_CHECKER  = 4'h4;
   localparam logic [3:0] MODE_LONG_PR  = 4'h5;
   localparam logic [3:0] MODE_SHORT_PR = 4'h6;
   localparam logic [3:0] MODE_TOGGLE   = 4'h7;
   localparam logic [3:0] MODE_USER     = 4'h8;
   localparam logic [3:0] MODE_RAMP     = 4'hf;
   // fixed words
   localparam logic [13:0] WORD_MIDSCALE = 14'h0000;
   localparam logic [13:0] WORD_POS_FS   = 14'h1fff;
   localparam logic [13:0] WORD_NEG_FS   = 14'h2000;
   localparam logic [13:0] WORD_CHECK_A  = 14'h1555;
   localparam logic [13:0] WORD_CHECK_B  = 14'h2aaa;
   localparam logic [13:0] WORD_ZEROS    = 14'h0000;
   localparam logic [13:0] WORD_ONES     = 14'h3fff;
   // pseudo-random generators
   localparam int unsigned LONG_W      = 23;
   localparam int unsigned LONG_TAP    = 18;
   localparam logic [22:0] LONG_SEED   = 23'h003aff;
   localparam int unsigned SHORT_W     = 9;
   localparam int unsigned SHORT_TAP   = 5;
   localparam logic [8:0]  SHORT_SEED  = 9'h092;
   // sample carrier
   typedef struct packed {
      logic        valid;
      logic [13:0] data;
   } atpg_sample_t;
endpackage : atpg_pkg

/* File: atpg_chk_sva.sv */
// port assertions for the converter test-pattern generator
`timescale 1ns/10ps
`default_nettype none
module atpg_chk #(
   parameter int unsigned ADDR_W = atpg_pkg::ADDR_W
) (
   input wire logic                   mclk,           // sample clock
   input wire logic                   rst_n,          // sync reset, active low
   input wire logic [ADDR_W-1:0]      reg_addr,       // register address
   input wire logic [7:0]             reg_wdata,      // write data
   input wire logic                   reg_we,         // write strobe
   input wire logic                   fmt_offset_bin, // offset binary select
   input wire atpg_pkg::atpg_sample_t adc_in,         // converter sample
   input wire logic [7:0]             reg_rdata,      // read data
   input wire atpg_pkg::atpg_sample_t data_out,       // generated sample
   input wire logic                   test_active     // pattern selected
);
   logic [3:0]  mode;   // shadow of the pattern code
   logic        fresh;  // code changed, no tick since
   logic [13:0] last_w; // last word put out
   wire  [13:0] cur_w = data_out.valid ? data_out.data : last_w;
   wire         wr_ctl = reg_we && reg_addr == atpg_pkg::OFS_CONTROL;
   // shadow of the code written to the control register
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mode  <= 4'h0;
         fresh <= 1'b0;
      end else if (wr_ctl) begin
         mode  <= reg_wdata[3:0];
         fresh <= reg_wdata[3:0] != mode;
      end else if (adc_in.valid) begin
         fresh <= 1'b0;
      end
   end
   // last delivered word, for step checks
   always_ff @(posedge mclk) begin
      if (!rst_n) last_w <= 14'h0000;
      else if (data_out.valid) last_w <= data_out.data;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_ramp;
      adc_in.valid && mode == atpg_pkg::MODE_RAMP;
   endsequence
   a_reset_quiet: assert property ($rose(rst_n) |-> !test_active && !data_out.valid && reg_rdata == 8'h00)
      else $error("outputs not cleared by reset");
   a_active_code: assert property (wr_ctl |-> ##2 test_active == ($past(mode) != 4'h0))
      else $error("test_active does not follow code");
   a_valid_follow: assert property (adc_in.valid |=> data_out.valid)
      else $error("sample tick lost");
   a_no_extra: assert property (!adc_in.valid |=> !data_out.valid)
      else $error("output without tick");
   a_pass_adc: assert property (adc_in.valid && mode == 4'h0 |=>
      (data_out.data ^ $past(adc_in.data)) == {$past(fmt_offset_bin), 13'h0000})
      else $error("converter data not passed");
   a_midscale_word: assert property (adc_in.valid && mode == 4'h1 |=>
      data_out.data == {$past(fmt_offset_bin), 13'h0000})
      else $error("midscale word wrong");
   a_negfs_word: assert property (adc_in.valid && mode == 4'h3 |=>
      data_out.data == {~$past(fmt_offset_bin), 13'h0000})
      else $error("negative full scale word wrong");
   a_check_first: assert property (adc_in.valid && fresh && mode == 4'h4 |=> data_out.data == 14'h1555)
      else $error("checkerboard phase wrong");
   a_ramp_start: assert property (s_ramp ##0 fresh |=> data_out.data == {$past(fmt_offset_bin), 13'h0000})
      else $error("ramp did not restart");
   a_ramp_step: assert property (s_ramp ##0 !fresh |=> data_out.data == $past(cur_w) + 14'h0001)
      else $error("ramp step wrong");
endmodule : atpg_chk
bind atpg_top atpg_chk #(.ADDR_W(ADDR_W)) atpg_chk_inst (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_we(reg_we), .fmt_offset_bin(fmt_offset_bin), .adc_in(adc_in),
   .reg_rdata(reg_rdata), .data_out(data_out), .test_active(test_active));
`default_nettype wire

/* File: test_atpg_top.sv */
// self-checking bench for the converter test-pattern generator
`timescale 1ns/10ps
`default_nettype none
module test_atpg_top;
   logic                   mclk;        // sample clock
   logic                   rst_n;       // sync reset, active low
   logic [11:0]            reg_addr;    // register address
   logic [7:0]             reg_wdata;   // write data
   logic                   reg_we;      // write strobe
   logic                   fmt;         // offset binary select
   atpg_pkg::atpg_sample_t adc_in;      // converter sample
   logic [7:0]             reg_rdata;   // read data
   atpg_pkg::atpg_sample_t data_out;    // generated sample
   logic                   test_active; // pattern selected
   int                     err_total;   // mismatches
   int                     checked;     // comparisons
   atpg_top atpg_top_inst (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .fmt_offset_bin(fmt), .adc_in(adc_in), .reg_rdata(reg_rdata),
      .data_out(data_out), .test_active(test_active));
   // 200 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic cmp_word(input string nm, input logic [13:0] e, input logic [13:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_word
   task automatic cmp_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_word(nm, {6'h00, e}, {6'h00, g});
   endtask : cmp_reg
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_we    <= 1'b1;
      @(posedge mclk);
      reg_we <= 1'b0;
   endtask : wr
   task automatic ctl(input logic [7:0] d);
      wr(atpg_pkg::OFS_CONTROL, d);
   endtask : ctl
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_addr <= a;
      @(posedge mclk);
      #1 cmp_reg("reg_rdata", e, reg_rdata);
   endtask : rd
   // one encode tick, then judge the word it produced
   task automatic tk(input logic [13:0] e);
      @(posedge mclk);
      adc_in <= '{valid: 1'b1, data: 14'h1234};
      @(posedge mclk);
      adc_in.valid <= 1'b0;
      #1 cmp_word("data_out", e, data_out.data);
   endtask : tk
   task automatic t_regs;
      cmp_word("test_active", 14'h0000, {13'h0000, test_active});
      rd(atpg_pkg::OFS_CONTROL, atpg_pkg::CONTROL_RESET);
      wr(atpg_pkg::OFS_USER_LAST, 8'h5a);
      rd(atpg_pkg::OFS_USER_LAST, 8'h5a);
      wr(12'h559, 8'h77);
      rd(12'h559, 8'h00);
   endtask : t_regs
   task automatic t_fixed;
      logic [13:0] w [4];
      w = '{14'h1234, 14'h0000, 14'h1fff, 14'h2000};
      for (int f = 0; f < 2; f++) begin
         fmt <= f[0];
         for (int c = 0; c < 4; c++) begin
            ctl(8'(c));
            tk(w[c] ^ {f[0], 13'h0000});
         end
      end
   endtask : t_fixed
   task automatic t_alt;
      ctl(8'h04);
      for (int i = 0; i < 4; i++) tk(i[0] ? 14'h2aaa : 14'h1555);
      ctl(8'h07);
      for (int i = 0; i < 4; i++) tk(i[0] ? 14'h3fff : 14'h0000);
   endtask : t_alt
   task automatic t_user;
      logic [15:0] p;
      for (int b = 0; b < 8; b++) wr(atpg_pkg::OFS_USER_BASE + 12'(b), 8'h11 * 8'(b + 1));
      for (int s = 0; s < 2; s++) begin
         ctl(8'h00);
         ctl(s[0] ? 8'h48 : 8'h08);
         for (int k = 0; k < 6; k++) begin
            p = {8'h11 * 8'(2 * (k % 4) + 2), 8'h11 * 8'(2 * (k % 4) + 1)};
            tk((s[0] && k > 3) ? 14'h0000 : p[15:2]);
         end
      end
      fmt <= 1'b0;
   endtask : t_user
   task automatic t_pr;
      ctl(8'h05);
      tk(14'h3fd7);
      tk(14'h0002);
      ctl(8'h15);
      ctl(8'h05);
      tk(14'h3fd7);
      ctl(8'h06);
      tk(14'h125b);
      tk(14'h3c9a);
      ctl(8'h26);
      ctl(8'h06);
      tk(14'h125b);
   endtask : t_pr
   task automatic t_ramp;
      ctl(8'h0f);
      for (int i = 0; i <= 16384; i++) tk(14'(i));
      fmt <= 1'b1;
      ctl(8'h00);
      ctl(8'h0f);
      tk(14'h2000);
   endtask : t_ramp
   // bound on the whole run
   initial begin
      #400000;
      err_total++;
      wrap_up();
   end
   initial begin
      rst_n = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 8'h00;
      reg_we = 1'b0;
      fmt = 1'b0;
      adc_in = '0;
      err_total = 0;
      checked = 0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      t_regs();
      t_fixed();
      t_alt();
      t_user();
      t_pr();
      t_ramp();
      wrap_up();
   end
endmodule : test_atpg_top
`default_nettype wire
